/* hdm_debug_csrs.v */
// Per-hart debug-mode control, status, return address and scratch
`timescale 1ns/1ns
`include "hdm_defines.vh"
module hdm_debug_csrs (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire dbg_int_i,
  input wire trig_hit_i,
  input wire ebreak_i,
  input wire retire_i,
  input wire dret_i,
  input wire [31:0] pc_i,
  input wire [1:0] priv_i,
  input wire csr_we_i,
  input wire csr_re_i,
  input wire [11:0] csr_addr_i,
  input wire [31:0] csr_wdata_i,
  output reg [31:0] csr_rdata_o,
  output wire csr_hit_o,
  output wire csr_illegal_o,
  output wire debug_mode_o,
  output wire enter_o,
  output wire [2:0] enter_cause_o,
  output wire resume_o,
  output wire [31:0] resume_pc_o,
  output wire [1:0] resume_priv_o,
  output wire irq_disable_o,
  output wire time_stop_o,
  output wire cycle_stop_o
);
  // ---------------------------------------------
  // Reset release and input capture
  // ---------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;
  wire dbg_int_sync;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;
  hdm_sync2 u_int_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .d_i(dbg_int_i),
    .q_o(dbg_int_sync)
  );
  // ---------------------------------------------
  // State registers
  // ---------------------------------------------
  reg dmode_reg;
  reg dmode_next;
  reg stepping_reg;
  reg stepping_next;
  reg halt_reg;
  reg halt_next;
  reg step_reg;
  reg step_next;
  reg stoptime_reg;
  reg stoptime_next;
  reg stopcyc_reg;
  reg stopcyc_next;
  reg [3:0] ebrk_reg;
  reg [3:0] ebrk_next;
  reg [2:0] cause_reg;
  reg [2:0] cause_next;
  reg [1:0] prv_reg;
  reg [1:0] prv_next;
  reg [31:0] ret_reg;
  reg [31:0] ret_next;
  reg [31:0] scratch_reg;
  reg [31:0] scratch_next;
  // ---------------------------------------------
  // Entry detection
  // ---------------------------------------------
  wire ebrk_en;
  wire swbrk_ev;
  wire step_ev;
  wire halt_ev;
  wire trig_ev;
  wire int_ev;
  wire any_ev;
  wire [2:0] pick_cause;
  wire enter;
  wire leave;
  assign ebrk_en = ebrk_reg[priv_i];
  assign swbrk_ev = !dmode_reg && ebreak_i && ebrk_en;
  assign trig_ev = !dmode_reg && trig_hit_i;
  assign int_ev = !dmode_reg && dbg_int_sync;
  assign step_ev = !dmode_reg && stepping_reg && retire_i;
  assign halt_ev = !dmode_reg && halt_reg;
  hdm_cause_pick u_pick (
    .trig_i(trig_ev),
    .swbrk_i(swbrk_ev),
    .dbgint_i(int_ev),
    .step_i(step_ev),
    .halt_i(halt_ev),
    .cause_o(pick_cause),
    .any_o(any_ev)
  );
  assign enter = any_ev;
  assign leave = dmode_reg && dret_i;
  // ---------------------------------------------
  // Register access
  // ---------------------------------------------
  wire sel_ctrl;
  wire sel_ret;
  wire sel_scr;
  wire access;
  wire wr_ok;
  wire [1:0] prv_w;
  wire prv_supported;
  wire [3:0] ebrk_wr;
  genvar gi;
  // ---------------------------------------------
  // Per-privilege ebreak enables
  // ---------------------------------------------
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ebrk
      assign ebrk_wr[gi] = csr_wdata_i[`HDM_EBRK_U_BIT+gi];
    end
  endgenerate
  assign sel_ctrl = csr_addr_i == `HDM_ADDR_CTRL;
  assign sel_ret = csr_addr_i == `HDM_ADDR_RET;
  assign sel_scr = csr_addr_i == `HDM_ADDR_SCRATCH;
  assign access = (csr_we_i | csr_re_i) & (sel_ctrl | sel_ret | sel_scr);
  assign csr_hit_o = access & dmode_reg;
  assign csr_illegal_o = access & !dmode_reg;
  assign wr_ok = csr_we_i & dmode_reg;
  assign prv_w = csr_wdata_i[`HDM_PRV_LSB+1:`HDM_PRV_LSB];
  assign prv_supported = (prv_w == `HDM_PRV_USER) ||
    (prv_w == `HDM_PRV_MACH);
  always @* begin
    dmode_next = dmode_reg;
    stepping_next = stepping_reg;
    halt_next = halt_reg;
    step_next = step_reg;
    stoptime_next = stoptime_reg;
    stopcyc_next = stopcyc_reg;
    ebrk_next = ebrk_reg;
    cause_next = cause_reg;
    prv_next = prv_reg;
    ret_next = ret_reg;
    scratch_next = scratch_reg;
    if (wr_ok && sel_ctrl) begin
      halt_next = csr_wdata_i[`HDM_HALT_BIT];
      step_next = csr_wdata_i[`HDM_STEP_BIT];
      stoptime_next = csr_wdata_i[`HDM_STOPTIME_BIT];
      stopcyc_next = csr_wdata_i[`HDM_STOPCYC_BIT];
      ebrk_next = ebrk_wr;
      if (prv_supported) begin
        prv_next = prv_w;
      end
    end
    if (wr_ok && sel_ret) begin
      ret_next = csr_wdata_i;
    end
    if (wr_ok && sel_scr) begin
      scratch_next = csr_wdata_i;
    end
    if (enter) begin
      dmode_next = 1'b1;
      stepping_next = 1'b0;
      cause_next = pick_cause;
      prv_next = priv_i;
      ret_next = pc_i;
    end else if (leave) begin
      dmode_next = 1'b0;
      stepping_next = step_reg;
      cause_next = `HDM_CAUSE_NONE;
    end
  end
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dmode_reg <= 1'b0;
      stepping_reg <= 1'b0;
      halt_reg <= 1'b0;
      step_reg <= 1'b0;
      stoptime_reg <= `HDM_STOPTIME_RST;
      stopcyc_reg <= `HDM_STOPCYC_RST;
      ebrk_reg <= `HDM_EBRK_RST;
      cause_reg <= `HDM_CAUSE_NONE;
      prv_reg <= `HDM_PRV_USER;
      ret_reg <= `HDM_WORD_RST;
      scratch_reg <= `HDM_WORD_RST;
    end else begin
      dmode_reg <= dmode_next;
      stepping_reg <= stepping_next;
      halt_reg <= halt_next;
      step_reg <= step_next;
      stoptime_reg <= stoptime_next;
      stopcyc_reg <= stopcyc_next;
      ebrk_reg <= ebrk_next;
      cause_reg <= cause_next;
      prv_reg <= prv_next;
      ret_reg <= ret_next;
      scratch_reg <= scratch_next;
    end
  end
  // ---------------------------------------------
  // Read data
  // ---------------------------------------------
  reg [31:0] ctrl_view;
  always @* begin
    ctrl_view = 32'h0;
    ctrl_view[`HDM_VER_LSB+1:`HDM_VER_LSB] = `HDM_VER_VAL;
    ctrl_view[`HDM_EBRK_M_BIT:`HDM_EBRK_U_BIT] = ebrk_reg;
    ctrl_view[`HDM_STOPCYC_BIT] = stopcyc_reg;
    ctrl_view[`HDM_STOPTIME_BIT] = stoptime_reg;
    ctrl_view[`HDM_CAUSE_LSB+2:`HDM_CAUSE_LSB] = cause_reg;
    ctrl_view[`HDM_DBGINT_BIT] = dbg_int_sync;
    ctrl_view[`HDM_HALT_BIT] = halt_reg;
    ctrl_view[`HDM_STEP_BIT] = step_reg;
    ctrl_view[`HDM_PRV_LSB+1:`HDM_PRV_LSB] = prv_reg;
  end
  always @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      csr_rdata_o <= 32'h0;
    end else if (csr_re_i && dmode_reg) begin
      if (sel_ctrl) begin
        csr_rdata_o <= ctrl_view;
      end else if (sel_ret) begin
        csr_rdata_o <= ret_reg;
      end else if (sel_scr) begin
        csr_rdata_o <= scratch_reg;
      end else begin
        csr_rdata_o <= 32'h0;
      end
    end else begin
      csr_rdata_o <= 32'h0;
    end
  end
  // ---------------------------------------------
  // Hart-facing controls
  // ---------------------------------------------
  assign debug_mode_o = dmode_reg;
  assign enter_o = enter;
  assign enter_cause_o = pick_cause;
  assign resume_o = leave;
  assign resume_pc_o = ret_reg;
  assign resume_priv_o = prv_reg;
  assign irq_disable_o = step_reg | stepping_reg;
  assign time_stop_o = dmode_reg & stoptime_reg;
  assign cycle_stop_o = dmode_reg & stopcyc_reg;
endmodule

/* hdm_defines.vh */
// Constants for the hart debug-mode register block
`ifndef HDM_DEFINES_VH
`define HDM_DEFINES_VH
// ---------------------------------------------
// Register addresses
// ---------------------------------------------
`define HDM_ADDR_CTRL 12'h7B0
`define HDM_ADDR_RET 12'h7B1
`define HDM_ADDR_SCRATCH 12'h7B2
// ---------------------------------------------
// Control/status field positions
// ---------------------------------------------
`define HDM_VER_LSB 30
`define HDM_EBRK_M_BIT 15
`define HDM_EBRK_H_BIT 14
`define HDM_EBRK_S_BIT 13
`define HDM_EBRK_U_BIT 12
`define HDM_STOPCYC_BIT 10
`define HDM_STOPTIME_BIT 9
`define HDM_CAUSE_LSB 6
`define HDM_DBGINT_BIT 5
`define HDM_HALT_BIT 3
`define HDM_STEP_BIT 2
`define HDM_PRV_LSB 0
// ---------------------------------------------
// Reset values and encodings
// ---------------------------------------------
`define HDM_VER_VAL 2'h1
`define HDM_CAUSE_NONE 3'h0
`define HDM_CAUSE_SWBRK 3'h1
`define HDM_CAUSE_TRIG 3'h2
`define HDM_CAUSE_DBGINT 3'h3
`define HDM_CAUSE_STEP 3'h4
`define HDM_CAUSE_HALT 3'h5
`define HDM_PRV_USER 2'h0
`define HDM_PRV_SUPER 2'h1
`define HDM_PRV_HYPER 2'h2
`define HDM_PRV_MACH 2'h3
`define HDM_STOPTIME_RST 1'h0
`define HDM_STOPCYC_RST 1'h1
`define HDM_EBRK_RST 4'h0
`define HDM_WORD_RST 32'h0
`endif

/* hdm_cause_pick.v */
// Priority encoder for the debug entry reason
`timescale 1ns/1ns
`include "hdm_defines.vh"
module hdm_cause_pick (
  input wire trig_i,
  input wire swbrk_i,
  input wire dbgint_i,
  input wire step_i,
  input wire halt_i,
  output reg [2:0] cause_o,
  output wire any_o
);
  assign any_o = trig_i | swbrk_i | dbgint_i | step_i | halt_i;
  always @* begin
    if (trig_i) begin
      cause_o = `HDM_CAUSE_TRIG;
    end else if (swbrk_i) begin
      cause_o = `HDM_CAUSE_SWBRK;
    end else if (dbgint_i) begin
      cause_o = `HDM_CAUSE_DBGINT;
    end else if (step_i) begin
      cause_o = `HDM_CAUSE_STEP;
    end else if (halt_i) begin
      cause_o = `HDM_CAUSE_HALT;
    end else begin
      cause_o = `HDM_CAUSE_NONE;
    end
  end
endmodule

/* hdm_sync2.v */
// Two-flop synchroniser for one level
`timescale 1ns/1ns
module hdm_sync2 (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire d_i,
  output reg q_o
);
  reg meta_reg;
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule

/* hdm_debug_csrs_assertions.sv */
// Checker for the hart debug-mode register block
`timescale 1ns/1ns
module hdm_debug_csrs_assertions (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire trig_hit_i,
  input wire [31:0] pc_i,
  input wire [1:0] priv_i,
  input wire csr_we_i,
  input wire csr_re_i,
  input wire [11:0] csr_addr_i,
  input wire [31:0] csr_rdata_o,
  input wire csr_hit_o,
  input wire csr_illegal_o,
  input wire debug_mode_o,
  input wire enter_o,
  input wire [2:0] enter_cause_o,
  input wire resume_o,
  input wire [31:0] resume_pc_o,
  input wire [1:0] resume_priv_o,
  input wire time_stop_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------
  // Entry sequences
  // ---------------------------------------------
  sequence s_capture;
    ##1 (debug_mode_o && resume_pc_o == $past(pc_i));
  endsequence
  sequence s_priv;
    ##1 (resume_priv_o == $past(priv_i));
  endsequence
  property p_capture;
    enter_o |-> s_capture;
  endproperty
  property p_priv;
    enter_o && priv_i[0] == priv_i[1] |-> s_priv;
  endproperty
  property p_cause;
    enter_o |-> enter_cause_o >= 3'h1 && enter_cause_o <= 3'h5;
  endproperty
  property p_trig;
    trig_hit_i && !debug_mode_o |-> enter_o && enter_cause_o == 3'h2;
  endproperty
  property p_resume;
    resume_o |=> !debug_mode_o;
  endproperty
  property p_time;
    time_stop_o |-> debug_mode_o;
  endproperty
  property p_refuse;
    (csr_re_i || csr_we_i) && csr_addr_i >= 12'h7B0 && csr_addr_i <= 12'h7B2
      && !debug_mode_o |-> csr_illegal_o && !csr_hit_o;
  endproperty
  property p_hit;
    (csr_re_i || csr_we_i) && csr_addr_i >= 12'h7B0 && csr_addr_i <= 12'h7B2
      && debug_mode_o |-> csr_hit_o && !csr_illegal_o;
  endproperty
  property p_idle;
    !csr_re_i |=> csr_rdata_o == 32'h0;
  endproperty
  a_capture: assert property (p_capture) else $error("pc capture");
  a_priv: assert property (p_priv) else $error("priv capture");
  a_cause: assert property (p_cause) else $error("bad cause");
  a_trig: assert property (p_trig) else $error("trigger cause");
  a_resume: assert property (p_resume) else $error("no exit");
  a_time: assert property (p_time) else $error("time stop");
  a_refuse: assert property (p_refuse) else $error("not refused");
  a_idle: assert property (p_idle) else $error("rdata not 0");
  a_hit: assert property (p_hit) else $error("not taken");
endmodule
bind hdm_debug_csrs hdm_debug_csrs_assertions u_hdm_debug_csrs_assertions (
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .trig_hit_i(trig_hit_i),
  .pc_i(pc_i),
  .priv_i(priv_i),
  .csr_we_i(csr_we_i),
  .csr_re_i(csr_re_i),
  .csr_addr_i(csr_addr_i),
  .csr_rdata_o(csr_rdata_o),
  .csr_hit_o(csr_hit_o),
  .csr_illegal_o(csr_illegal_o),
  .debug_mode_o(debug_mode_o),
  .enter_o(enter_o),
  .enter_cause_o(enter_cause_o),
  .resume_o(resume_o),
  .resume_pc_o(resume_pc_o),
  .resume_priv_o(resume_priv_o),
  .time_stop_o(time_stop_o)
);

/* hdm_debugger_model.sv */
// Debugger code model issuing register accesses
`timescale 1ns/1ns
module hdm_debugger_model (
  input wire ref_clk_i,
  input wire [31:0] csr_rdata_i,
  output logic csr_we_o,
  output logic csr_re_o,
  output logic [11:0] csr_addr_o,
  output logic [31:0] csr_wdata_o
);
  initial begin
    csr_we_o = 1'b0;
    csr_re_o = 1'b0;
    csr_addr_o = 12'h000;
    csr_wdata_o = 32'h0;
  end
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    #1 csr_re_o = 1'b1;
    csr_addr_o = a;
    @(posedge ref_clk_i);
    #1 csr_re_o = 1'b0;
    d = csr_rdata_i;
    csr_addr_o = ~a;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    #1 csr_we_o = 1'b1;
    csr_addr_o = a;
    csr_wdata_o = v;
    @(posedge ref_clk_i);
    #1 csr_we_o = 1'b0;
    csr_wdata_o = ~v;
  endtask
  // Write, then read back to learn what stuck
  task automatic wrrb(input logic [11:0] a, input logic [31:0] v,
                      output logic [31:0] d);
    wr(a, v);
    rd(a, d);
  endtask
  // Saved privilege shown as a virtual register
  task automatic rd_priv(output logic [1:0] p);
    logic [31:0] v;
    rd(12'h7B0, v);
    p = v[1:0];
  endtask
endmodule

/* tb_hart_debug_mode_csrs.sv */
// Testbench for the hart debug-mode register block
`timescale 1ns/1ns
module tb_hart_debug_mode_csrs;
  logic clk = 1'b0, rst_n = 1'b0, dbg_int = 1'b0, trig = 1'b0;
  logic ebrk = 1'b0, retire = 1'b0, dret = 1'b0;
  logic [31:0] pc = 32'h0, d;
  logic [1:0] priv = 2'h0, pv;
  wire we, re, hit, ill, dbg, ent, res, irqd, tstop, cstop;
  wire [11:0] addr;
  wire [31:0] wdata, rdata, rpc;
  wire [2:0] cause;
  wire [1:0] rprv;
  int err_count = 0, checks_done = 0, cyc = 0;
  hdm_debug_csrs u_hdm_debug_csrs (.ref_clk_i(clk), .rst_n_i(rst_n),
    .dbg_int_i(dbg_int), .trig_hit_i(trig), .ebreak_i(ebrk),
    .retire_i(retire), .dret_i(dret), .pc_i(pc), .priv_i(priv),
    .csr_we_i(we), .csr_re_i(re), .csr_addr_i(addr), .csr_wdata_i(wdata),
    .csr_rdata_o(rdata), .csr_hit_o(hit), .csr_illegal_o(ill),
    .debug_mode_o(dbg), .enter_o(ent), .enter_cause_o(cause),
    .resume_o(res), .resume_pc_o(rpc), .resume_priv_o(rprv),
    .irq_disable_o(irqd), .time_stop_o(tstop), .cycle_stop_o(cstop));
  hdm_debugger_model u_hdm_debugger_model (.ref_clk_i(clk),
    .csr_rdata_i(rdata), .csr_we_o(we), .csr_re_o(re), .csr_addr_o(addr),
    .csr_wdata_o(wdata));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      summarize();
    end
  end
  task automatic t_refused();
    fork
      u_hdm_debugger_model.rd(12'h7B0, d);
      begin
        @(posedge clk);
        #3 chk("illegal", 1, ill);
      end
    join
    chk("refused rdata", 0, d);
    $display("test refused done");
  endtask
  task automatic t_entry();
    @(posedge clk);
    #1 trig = 1'b1;
    pc = 32'h12345678;
    priv = 2'h3;
    #2 chk("enter", 1, ent);
    chk("cause", 2, cause);
    @(posedge clk);
    #1 trig = 1'b0;
    chk("debug", 1, dbg);
    chk("time stop", 0, tstop);
    chk("cycle stop", 1, cstop);
    u_hdm_debugger_model.rd(12'h7B0, d);
    chk("ctrl", 32'h40000483, d);
    u_hdm_debugger_model.rd(12'h7B1, d);
    chk("ret", 32'h12345678, d);
    $display("test entry done");
  endtask
  task automatic t_regs();
    u_hdm_debugger_model.wrrb(12'h7B2, 32'hA5A55A5A, d);
    chk("scratch", 32'hA5A55A5A, d);
    u_hdm_debugger_model.wr(12'h7B1, 32'h00000400);
    u_hdm_debugger_model.wrrb(12'h7B0, 32'h00000601, d);
    chk("ctrl wr", 32'h40000683, d);
    chk("time stop", 1, tstop);
    u_hdm_debugger_model.wr(12'h7B0, 32'h00000608);
    chk("rprv", 0, rprv);
    u_hdm_debugger_model.rd_priv(pv);
    chk("virtual priv", 0, pv);
    @(posedge clk);
    #1 dret = 1'b1;
    #2 chk("resume", 1, res);
    chk("rpc", 32'h00000400, rpc);
    @(posedge clk);
    #1 dret = 1'b0;
    chk("left", 0, dbg);
    chk("halt enter", 1, ent);
    chk("halt cause", 5, cause);
    @(posedge clk);
    $display("test regs done");
  endtask
  task automatic t_step();
    u_hdm_debugger_model.wr(12'h7B0, 32'h00000607);
    chk("irq off", 1, irqd);
    @(posedge clk);
    #1 dret = 1'b1;
    @(posedge clk);
    #1 dret = 1'b0;
    chk("left", 0, dbg);
    chk("no early enter", 0, ent);
    @(posedge clk);
    #1 retire = 1'b1;
    pc = 32'h00002000;
    #2 chk("step enter", 1, ent);
    chk("step cause", 4, cause);
    @(posedge clk);
    #1 retire = 1'b0;
    u_hdm_debugger_model.rd(12'h7B1, d);
    chk("step ret", 32'h00002000, d);
    $display("test step done");
  endtask
  task automatic t_prio();
    u_hdm_debugger_model.wr(12'h7B0, 32'h0000800B);
    chk("irq on", 0, irqd);
    @(posedge clk);
    #1 dret = 1'b1;
    @(posedge clk);
    #1 dret = 1'b0;
    ebrk = 1'b1;
    #2 chk("prio enter", 1, ent);
    chk("prio cause", 1, cause);
    @(posedge clk);
    #1 ebrk = 1'b0;
    chk("prio cstop", 0, cstop);
    chk("prio tstop", 0, tstop);
    u_hdm_debugger_model.rd(12'h7B0, d);
    chk("prio ctrl", 32'h4000804B, d);
    $display("test prio done");
  endtask
  task automatic t_dbgint();
    dbg_int = 1'b1;
    repeat (4) @(posedge clk);
    u_hdm_debugger_model.rd(12'h7B0, d);
    chk("dbgint", 1, d[5]);
    @(posedge clk);
    #1 dret = 1'b1;
    @(posedge clk);
    #1 dret = 1'b0;
    #2 chk("int enter", 1, ent);
    chk("int cause", 3, cause);
    @(posedge clk);
    #1 dbg_int = 1'b0;
    repeat (4) @(posedge clk);
    u_hdm_debugger_model.rd(12'h7B0, d);
    chk("dbgint low", 0, d[5]);
    $display("test dbgint done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_refused();
    t_entry();
    t_regs();
    t_step();
    t_prio();
    t_dbgint();
    summarize();
  end
endmodule
